// >>> hw/tlic_pkg.sv
// package: register offsets, layout and timing constants of the interrupt controller
package tlic_pkg;
   // register offsets, one byte-wide register per word
   localparam logic [7:0] ADDR_FIRST_LEVEL = 8'h00;
   localparam logic [7:0] ADDR_FIRST_MASK = 8'h01;
   localparam logic [7:0] ADDR_POWER_SOURCE = 8'h02;
   localparam logic [7:0] ADDR_THERMAL_ALERT = 8'h03;
   localparam logic [7:0] ADDR_THERMAL_CRITICAL = 8'h04;
   localparam logic [7:0] ADDR_BATTERY_THERMAL = 8'h05;
   localparam logic [7:0] ADDR_BURST_CONTROL = 8'h06;
   localparam logic [7:0] ADDR_CONVERTER_DONE = 8'h07;
   localparam logic [7:0] ADDR_CHARGER = 8'h08;
   localparam logic [7:0] ADDR_PIN_EDGE = 8'h09;
   localparam logic [7:0] ADDR_HDMI_SUPPLY = 8'h0A;
   localparam logic [7:0] ADDR_MASK_BASE = 8'h10;
   localparam logic [7:0] ADDR_EDGE_RISE = 8'h20;
   localparam logic [7:0] ADDR_EDGE_FALL = 8'h21;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;
   // number of second-level registers and first-level bits
   localparam int NUM_GROUPS = 9;
   localparam int NUM_FIRST = 6;
   // second-level register index
   localparam int G_POWER = 0;
   localparam int G_TALERT = 1;
   localparam int G_TCRIT = 2;
   localparam int G_TBATT = 3;
   localparam int G_BURST = 4;
   localparam int G_CONV = 5;
   localparam int G_CHARGER = 6;
   localparam int G_PIN = 7;
   localparam int G_HDMI = 8;
   // first-level bit positions
   localparam int F_POWER = 0;
   localparam int F_THERMAL = 1;
   localparam int F_BURST = 2;
   localparam int F_CONV = 3;
   localparam int F_CHARGER_PIN = 4;
   localparam int F_HDMI = 5;
   // implemented bits per second-level register
   localparam logic [7:0] WIDTH_MASK [NUM_GROUPS] = '{8'h07, 8'hFF, 8'h0F, 8'h3F,
      8'h07, 8'hFF, 8'h01, 8'hFF, 8'h01};
   // reset values: every source masked off, edge detection off
   localparam logic [7:0] MASK_RESET = 8'hFF;
   localparam logic [5:0] FIRST_MASK_RESET = 6'h3F;
   localparam logic [7:0] EDGE_RESET = 8'h00;
   // charger request low-time and its count at 40 MHz
   localparam int CLOCK_HZ = 40_000_000;
   localparam int CHARGER_LOW_US = 200;
   localparam int CHARGER_LOW_CYCLES = (CHARGER_LOW_US * (CLOCK_HZ / 1_000_000));
endpackage : tlic_pkg

// >>> hw/tlic_edge.sv
// both-edge detector with per-bit rising and falling selection
`timescale 1ns/1ps
module tlic_edge
   import tlic_pkg::*;
#(
   parameter int WIDTH = 8
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // level inputs and edge selection
   input wire logic [WIDTH-1:0] level,
   input wire logic [WIDTH-1:0] on_rise,
   input wire logic [WIDTH-1:0] on_fall,
   // one-cycle event per bit
   output logic [WIDTH-1:0] event_pulse
);
   typedef struct packed {
      logic [WIDTH-1:0] last;
      logic primed;
   } tlic_edge_state_t;
   tlic_edge_state_t state;
   tlic_edge_state_t next_state;

   // first cycle after reset only takes a reference, so no false edge appears
   always_comb begin
      next_state = state;
      next_state.last = level;
      next_state.primed = 1'b1;
   end

   // selected edges, held back until a reference level exists
   assign event_pulse = state.primed ?
      (((level & ~state.last) & on_rise) | ((~level & state.last) & on_fall)) :
      {WIDTH{1'b0}};

   always_ff @(posedge core_clk) begin
      if (reset) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end
endmodule : tlic_edge

// >>> hw/tlic_pulse_filter.sv
// low-time qualifier for the external charger request input
`timescale 1ns/1ps
module tlic_pulse_filter
   import tlic_pkg::*;
#(
   parameter int LOW_CYCLES = CHARGER_LOW_CYCLES
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // active-low request from the charger
   input wire logic request_n,
   // one pulse per qualified low period
   output logic request_event
);
   typedef struct packed {
      logic [15:0] count;
      logic fired;
   } tlic_filter_state_t;
   tlic_filter_state_t state;
   tlic_filter_state_t next_state;
   localparam logic [15:0] LIMIT = 16'(LOW_CYCLES - 1);

   // count low time; one event per low period so a long low does not retrigger
   always_comb begin
      next_state = state;
      if (request_n) begin
         next_state.count = 16'h0000;
         next_state.fired = 1'b0;
      end else if (state.count != LIMIT) begin
         next_state.count = state.count + 16'h0001;
      end else begin
         next_state.fired = 1'b1;
      end
   end

   // shorter glitches never reach the limit and are dropped
   assign request_event = !request_n && (state.count == LIMIT) && !state.fired;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end
endmodule : tlic_pulse_filter

// >>> hw/tlic_controller.sv
// two-level interrupt controller top: sources, sticky status, masks, pin
//
// Notes on behaviour
// - irq pin stays high while any unmasked interrupt is still uncleared
// - first-level register has six bits, one per interrupt-causing sub-block
// - masked sub-block sets no first-level bit and does not raise the pin
// - first-level bits ignore writes and clear when their second-level bits clear
// - pin drops once all unmasked first-level bits are implicitly cleared
// - set unmasked second-level bit propagates to its sub-block's first-level bit
// - masked second-level bit never sets and never contributes upward
// - power-source group: usb, adapter, battery detect, on insertion and removal
// - thermal alert register: level 0 and 1 for three thermistors and die
// - thermal critical register: critical for three thermistors and die
// - battery thermal register: alert 0, alert 1, critical for two thermistors
// - burst-control group: warn b, warn a, critical, on every crossing
// - converter group: one bit per manual conversion done on eight channels
// - charger group bit sets when the external charger requests an interrupt
// - each input pin raises its bit on rising, falling or both edges
// - hdmi supply overcurrent sets its bit when unmasked
`timescale 1ns/1ps
module tlic_controller
   import tlic_pkg::*;
#(
   parameter int PIN_COUNT = 8,
   parameter int CHARGER_CYCLES = CHARGER_LOW_CYCLES
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   // power-source detect levels: usb, adapter, battery
   input wire logic [2:0] power_source_level,
   // thermal state machine event pulses
   input wire logic [7:0] thermal_alert_event,
   input wire logic [3:0] thermal_critical_event,
   input wire logic [5:0] battery_thermal_event,
   // supply comparator levels: warn b, warn a, critical
   input wire logic [2:0] supply_compare_level,
   // converter manual conversion done pulses
   input wire logic [7:0] converter_done_event,
   // external charger request, active low
   input wire logic charger_request_n,
   // general-purpose input levels
   input wire logic [PIN_COUNT-1:0] pin_level,
   // hdmi supply overcurrent level
   input wire logic hdmi_supply_overcurrent,
   // interrupt to the application processor, active high
   output logic irq
);

   // one record holds all state:
   //   status: sticky second-level bits
   //   mask: second-level masks, one masks
   //   first_mask: first-level masks
   //   edge_rise, edge_fall: pin edge selects
   //   first_level: rolled-up unmasked groups
   //   irq: registered pin, glitch free
   //   rdata: registered read data
   typedef struct packed {
      logic [NUM_GROUPS-1:0][7:0] status;
      logic [NUM_GROUPS-1:0][7:0] mask;
      logic [NUM_FIRST-1:0] first_mask;
      logic [PIN_COUNT-1:0] edge_rise;
      logic [PIN_COUNT-1:0] edge_fall;
      logic [NUM_FIRST-1:0] first_level;
      logic irq;
      logic [7:0] rdata;
   } tlic_state_t;
   tlic_state_t state;
   tlic_state_t next_state;

   logic [2:0] power_event;
   logic [2:0] supply_event;
   logic [PIN_COUNT-1:0] pin_event;
   logic [0:0] hdmi_event;
   logic charger_event;
   logic [NUM_GROUPS-1:0][7:0] raw_event;
   logic [NUM_FIRST-1:0] first_raw;

   // register map:
   //   00 first-level status, read only
   //   01 first-level mask
   //   02 power source
   //   03 thermal alert
   //   04 thermal critical
   //   05 battery thermal
   //   06 burst control
   //   07 converter done
   //   08 charger
   //   09 pin edge
   //   0A hdmi supply
   //   10 to 18: masks, same order
   //   20 and 21: pin rise and fall selects
   //   others read zero, writes ignored
   // status registers clear by writing ones

   // first-level bits:
   //   [0] power source
   //   [1] thermal, three registers
   //   [2] burst control
   //   [3] converter
   //   [4] charger and pins
   //   [5] hdmi supply
   // nine groups on six bits: on bit 1 or 4
   // the host must read every group behind it

   // fixed mapping of a second-level register onto its first-level bit
   function automatic int first_of(input int group);
      case (group)
         G_POWER: first_of = F_POWER;
         G_TALERT, G_TCRIT, G_TBATT: first_of = F_THERMAL;
         G_BURST: first_of = F_BURST;
         G_CONV: first_of = F_CONV;
         G_CHARGER, G_PIN: first_of = F_CHARGER_PIN;
         default: first_of = F_HDMI;
      endcase
   endfunction : first_of

   // second-level register index addressed, or NUM_GROUPS if none
   function automatic int group_of(input logic [7:0] addr, input logic [7:0] base);
      group_of = NUM_GROUPS;
      for (int g = 0; g < NUM_GROUPS; g++) begin
         if (addr == base + 8'(g)) begin
            group_of = g;
         end
      end
   endfunction : group_of

   // insertion and removal both count
   tlic_edge #(
      .WIDTH(3)
   ) u_power_edge (
      .core_clk(core_clk),
      .reset(reset),
      .level(power_source_level),
      .on_rise(3'h7),
      .on_fall(3'h7),
      .event_pulse(power_event)
   );

   // every threshold crossing, rising or falling
   tlic_edge #(
      .WIDTH(3)
   ) u_supply_edge (
      .core_clk(core_clk),
      .reset(reset),
      .level(supply_compare_level),
      .on_rise(3'h7),
      .on_fall(3'h7),
      .event_pulse(supply_event)
   );

   // programmable edge per pin
   tlic_edge #(
      .WIDTH(PIN_COUNT)
   ) u_pin_edge (
      .core_clk(core_clk),
      .reset(reset),
      .level(pin_level),
      .on_rise(state.edge_rise),
      .on_fall(state.edge_fall),
      .event_pulse(pin_event)
   );

   // overcurrent onset only, so a held fault does not re-set after a clear
   tlic_edge #(
      .WIDTH(1)
   ) u_hdmi_edge (
      .core_clk(core_clk),
      .reset(reset),
      .level(hdmi_supply_overcurrent),
      .on_rise(1'b1),
      .on_fall(1'b0),
      .event_pulse(hdmi_event)
   );

   // the charger keeps its request low long enough for this qualifier
   tlic_pulse_filter #(
      .LOW_CYCLES(CHARGER_CYCLES)
   ) u_charger_filter (
      .core_clk(core_clk),
      .reset(reset),
      .request_n(charger_request_n),
      .request_event(charger_event)
   );

   // second-level bit layout
   // power source:
   //   [0] usb supply
   //   [1] adapter
   //   [2] battery
   // thermal alert:
   //   [3:0] level 0
   //   [7:4] level 1
   //   nibble order sys0, sys1, sys2, die
   // thermal critical:
   //   [0] sys0
   //   [1] sys1
   //   [2] sys2
   //   [3] die
   // battery thermal:
   //   [1:0] alert 0
   //   [3:2] alert 1
   //   [5:4] critical
   //   pair order thermistor 0, thermistor 1
   // burst control:
   //   [0] warn b
   //   [1] warn a
   //   [2] critical
   // converter:
   //   [0] vbat
   //   [1] battery id
   //   [2] die temperature
   //   [3] pack 0
   //   [4] pack 1
   //   [5] sys0
   //   [6] sys1
   //   [7] sys2
   // charger:
   //   [0] qualified request
   // pins: one bit per pin
   // hdmi supply:
   //   [0] overcurrent onset
   // bits above a group's width never set

   // gather raw events into second-level positions
   always_comb begin
      raw_event = '0;
      raw_event[G_POWER][2:0] = power_event;
      raw_event[G_TALERT] = thermal_alert_event;
      raw_event[G_TCRIT][3:0] = thermal_critical_event;
      raw_event[G_TBATT][5:0] = battery_thermal_event;
      raw_event[G_BURST][2:0] = supply_event;
      raw_event[G_CONV] = converter_done_event;
      raw_event[G_CHARGER][0] = charger_event;
      raw_event[G_PIN][PIN_COUNT-1:0] = pin_event;
      raw_event[G_HDMI][0] = hdmi_event[0];
   end

   // timing for an event sampled at edge n:
   //   status set after edge n
   //   first-level bit after edge n+1
   //   irq after edge n+2
   // a clear written at edge w drops irq after w+2
   // a first-level mask write at w drops irq after w+1
   // registering irq costs a cycle of latency
   // but keeps the pin free of decode glitches
   // a level source held steady makes no events,
   // so clearing its bit does not bring it back

   // next state: sticky status, write-one clear, register writes, roll-up
   always_comb begin
      int wg;
      int mg;
      logic [7:0] clear;
      wg = group_of(reg_addr, ADDR_POWER_SOURCE);
      mg = group_of(reg_addr, ADDR_MASK_BASE);
      clear = 8'h00;
      next_state = state;
      first_raw = '0;
      for (int g = 0; g < NUM_GROUPS; g++) begin
         clear = (reg_write && wg == g) ? reg_wdata : 8'h00;
         // a new event in the same cycle beats the clear
         next_state.status[g] = ((state.status[g] & ~clear) |
            (raw_event[g] & ~state.mask[g])) & WIDTH_MASK[g];
         if (reg_write && mg == g) begin
            next_state.mask[g] = reg_wdata & WIDTH_MASK[g];
         end
         // masking a bit later also stops it counting upward
         first_raw[first_of(g)] = first_raw[first_of(g)] |
            (|(state.status[g] & ~state.mask[g]));
      end
      if (reg_write && reg_addr == ADDR_FIRST_MASK) begin
         next_state.first_mask = reg_wdata[NUM_FIRST-1:0];
      end
      if (reg_write && reg_addr == ADDR_EDGE_RISE) begin
         next_state.edge_rise = reg_wdata[PIN_COUNT-1:0];
      end
      if (reg_write && reg_addr == ADDR_EDGE_FALL) begin
         next_state.edge_fall = reg_wdata[PIN_COUNT-1:0];
      end
      // first level has no write path; it follows the unmasked status
      next_state.first_level = first_raw & ~state.first_mask;
      next_state.irq = |(state.first_level & ~state.first_mask);
      // host service: read first level, then the groups behind it,
      // then write back the bits seen; a bit that sets in between
      // stays set and keeps irq up for the next pass
      // reads have no side effect, so polling is safe
      // read data one cycle after the strobe, zero otherwise
      next_state.rdata = 8'h00;
      if (reg_read) begin
         if (reg_addr == ADDR_FIRST_LEVEL) begin
            next_state.rdata = {2'b00, state.first_level & ~state.first_mask};
         end else if (reg_addr == ADDR_FIRST_MASK) begin
            next_state.rdata = {2'b00, state.first_mask};
         end else if (wg < NUM_GROUPS) begin
            next_state.rdata = state.status[wg];
         end else if (mg < NUM_GROUPS) begin
            next_state.rdata = state.mask[mg];
         end else if (reg_addr == ADDR_EDGE_RISE) begin
            next_state.rdata = 8'(state.edge_rise);
         end else if (reg_addr == ADDR_EDGE_FALL) begin
            next_state.rdata = 8'(state.edge_fall);
         end else begin
            next_state.rdata = READ_UNMAPPED;
         end
      end
   end

   // outputs straight from flip-flops
   assign reg_rdata = state.rdata;
   assign irq = state.irq;

   // after reset:
   //   status, first level, irq and read data are zero
   //   every implemented mask bit is set
   //   first-level mask is all ones
   //   edge selects are zero, so pins raise nothing
   // software unmasks only what it can service;
   // a source unmasked while its level is high
   // raises nothing until its next edge

   // everything comes up masked so nothing interrupts before software is ready
   always_ff @(posedge core_clk) begin
      if (reset) begin
         state <= '0;
         for (int g = 0; g < NUM_GROUPS; g++) begin
            state.mask[g] <= MASK_RESET & WIDTH_MASK[g];
         end
         state.first_mask <= FIRST_MASK_RESET;
         state.edge_rise <= PIN_COUNT'(EDGE_RESET);
         state.edge_fall <= PIN_COUNT'(EDGE_RESET);
      end else begin
         state <= next_state;
      end
   end
endmodule : tlic_controller

// >>> bench/tlic_props.sv
// checker: port-level properties of the two-level interrupt controller
`timescale 1ns/1ps
module tlic_props
   import tlic_pkg::*;
#(
   parameter int PIN_COUNT = 8,
   parameter int CHARGER_CYCLES = CHARGER_LOW_CYCLES
) (
   // clock, reset and register port
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [7:0] reg_rdata,
   // sources and interrupt pin
   input wire logic [2:0] power_source_level,
   input wire logic [7:0] thermal_alert_event,
   input wire logic [3:0] thermal_critical_event,
   input wire logic [5:0] battery_thermal_event,
   input wire logic [2:0] supply_compare_level,
   input wire logic [7:0] converter_done_event,
   input wire logic charger_request_n,
   input wire logic [PIN_COUNT-1:0] pin_level,
   input wire logic hdmi_supply_overcurrent,
   input wire logic irq
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (reset);
   logic [7:0] mask [NUM_GROUPS];
   logic [5:0] fmask;
   logic st_rd;
   logic [3:0] st_idx;
   logic [7:0] st_mask;
   logic [7:0] st_width;
   // shadow of the mask registers, changed only by writes
   always_ff @(posedge core_clk) begin
      if (reset) begin
         fmask <= FIRST_MASK_RESET;
         for (int i = 0; i < NUM_GROUPS; i++) begin
            mask[i] <= MASK_RESET;
         end
      end else if (reg_write) begin
         if (reg_addr == ADDR_FIRST_MASK) begin
            fmask <= reg_wdata[5:0];
         end
         for (int i = 0; i < NUM_GROUPS; i++) begin
            if (reg_addr == ADDR_MASK_BASE + 8'(i)) begin
               mask[i] <= reg_wdata;
            end
         end
      end
   end
   // status read decode; index forced to 0 off range so lookups stay legal
   always_comb begin
      st_rd = reg_read && reg_addr >= ADDR_POWER_SOURCE && reg_addr <= ADDR_HDMI_SUPPLY;
      st_idx = st_rd ? 4'(reg_addr - ADDR_POWER_SOURCE) : 4'h0;
      st_mask = mask[st_idx];
      st_width = WIDTH_MASK[st_idx];
   end
   AST_RDATA_IDLE: assert property (!reg_read |=> reg_rdata == 8'h00)
      else $error("read data not zero outside a read");
   AST_FIRST_WIDTH: assert property (
      reg_read && reg_addr == ADDR_FIRST_LEVEL |=> reg_rdata[7:6] == 2'b00)
      else $error("first level shows more than six bits");
   AST_FIRST_MASKED: assert property (
      reg_read && reg_addr == ADDR_FIRST_LEVEL |=> (reg_rdata[5:0] & $past(fmask)) == 6'h00)
      else $error("masked first level bit reads set");
   AST_MASKED_NEVER_SET: assert property (st_rd |=> (reg_rdata & $past(st_mask)) == 8'h00)
      else $error("masked second level bit reads set");
   AST_STATUS_WIDTH: assert property (st_rd |=> (reg_rdata & ~$past(st_width)) == 8'h00)
      else $error("unimplemented status bit reads set");
   AST_IRQ_HOLD: assert property (
      irq && !reg_write && !$past(reg_write) && !$past(reg_write, 2) |=> irq)
      else $error("irq dropped with no clear or mask write");
   AST_CONV_IRQ: assert property (
      (converter_done_event & ~mask[G_CONV]) != 8'h00 && !fmask[F_CONV] |-> ##3 irq)
      else $error("unmasked conversion done did not raise irq in three cycles");
   AST_HDMI_IRQ: assert property (
      $rose(hdmi_supply_overcurrent) && !mask[G_HDMI][0] && !fmask[F_HDMI] |-> ##[3:4] irq)
      else $error("unmasked overcurrent did not raise irq");
endmodule : tlic_props
bind tlic_controller tlic_props #(.PIN_COUNT(PIN_COUNT), .CHARGER_CYCLES(CHARGER_CYCLES))
   u_props (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
   .reg_rdata(reg_rdata), .power_source_level(power_source_level),
   .thermal_alert_event(thermal_alert_event),
   .thermal_critical_event(thermal_critical_event),
   .battery_thermal_event(battery_thermal_event),
   .supply_compare_level(supply_compare_level),
   .converter_done_event(converter_done_event),
   .charger_request_n(charger_request_n), .pin_level(pin_level),
   .hdmi_supply_overcurrent(hdmi_supply_overcurrent), .irq(irq));

// >>> bench/tlic_host.sv
// host model: register-bus master and interrupt service of the processor
`timescale 1ns/1ps
module tlic_host
   import tlic_pkg::*;
(
   // clock and interrupt pin
   input wire logic core_clk,
   input wire logic irq,
   // register port
   output logic [7:0] reg_addr = 8'h00,
   output logic [7:0] reg_wdata = 8'h00,
   output logic reg_write = 1'b0,
   output logic reg_read = 1'b0,
   input wire logic [7:0] reg_rdata
);
   // one-cycle write strobe launched just after an edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_write <= 1'b0;
   endtask : wr
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_read <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   // find the cause top-down, then clear exactly what was seen
   task automatic service(input logic [7:0] a, output logic [7:0] f, output logic [7:0] s);
      rd(ADDR_FIRST_LEVEL, f);
      rd(a, s);
      wr(a, s);
   endtask : service
endmodule : tlic_host

// >>> bench/tb_tlic_controller.sv
// testbench: scenarios and verdict for the two-level interrupt controller
`timescale 1ns/1ps
module tb_tlic_controller;
   import tlic_pkg::*;
   // short charger low-time keeps the run brief
   localparam int CHG = 4;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic reg_write;
   logic reg_read;
   logic irq;
   logic [2:0] power_source_level = 3'h0;
   logic [7:0] thermal_alert_event = 8'h00;
   logic [3:0] thermal_critical_event = 4'h0;
   logic [5:0] battery_thermal_event = 6'h00;
   logic [2:0] supply_compare_level = 3'h0;
   logic [7:0] converter_done_event = 8'h00;
   logic charger_request_n = 1'b1;
   logic [7:0] pin_level = 8'h00;
   logic hdmi_supply_overcurrent = 1'b0;
   logic [7:0] v;
   logic [7:0] f;
   int bad_count = 0;
   int compares = 0;
   int cycles = 0;
   always #12.5 core_clk = ~core_clk;
   tlic_controller #(.PIN_COUNT(8), .CHARGER_CYCLES(CHG)) u_dut (.*);
   tlic_host u_host (.*);
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
      end
   endtask : check
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      u_host.rd(a, v);
      check(v, e);
   endtask : rc
   task automatic ci(input logic e);
      check({7'h00, irq}, {7'h00, e});
   endtask : ci
   // ends just after an edge so outputs have settled
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : tick
   task automatic pconv(input logic [7:0] e);
      @(posedge core_clk);
      converter_done_event <= e;
      @(posedge core_clk);
      converter_done_event <= 8'h00;
   endtask : pconv
   task automatic t_reset;
      ci(1'b0);
      rc(ADDR_FIRST_MASK, {2'b00, FIRST_MASK_RESET});
      for (int g = 0; g < NUM_GROUPS; g++) begin
         rc(ADDR_MASK_BASE + 8'(g), MASK_RESET & WIDTH_MASK[g]);
         rc(ADDR_POWER_SOURCE + 8'(g), 8'h00);
      end
      rc(ADDR_EDGE_RISE, EDGE_RESET);
      rc(8'h30, READ_UNMAPPED);
      u_host.wr(ADDR_FIRST_MASK, 8'h00);
   endtask : t_reset
   task automatic t_conv;
      u_host.wr(ADDR_MASK_BASE + 8'(G_CONV), 8'h00);
      pconv(8'h81);
      tick(3);
      ci(1'b1);
      rc(ADDR_FIRST_LEVEL, 8'h08);
      rc(ADDR_CONVERTER_DONE, 8'h81);
      u_host.wr(ADDR_FIRST_LEVEL, 8'hFF);
      rc(ADDR_FIRST_LEVEL, 8'h08);
      u_host.wr(ADDR_CONVERTER_DONE, 8'h01);
      tick(4);
      ci(1'b1);
      rc(ADDR_CONVERTER_DONE, 8'h80);
      u_host.wr(ADDR_CONVERTER_DONE, 8'h80);
      tick(4);
      ci(1'b0);
      rc(ADDR_FIRST_LEVEL, 8'h00);
   endtask : t_conv
   task automatic t_mask;
      u_host.wr(ADDR_MASK_BASE + 8'(G_CONV), 8'hFE);
      pconv(8'hFF);
      rc(ADDR_CONVERTER_DONE, 8'h01);
      u_host.wr(ADDR_FIRST_MASK, 8'h08);
      tick(4);
      ci(1'b0);
      rc(ADDR_FIRST_LEVEL, 8'h00);
      u_host.wr(ADDR_CONVERTER_DONE, 8'hFF);
      u_host.wr(ADDR_FIRST_MASK, 8'h00);
   endtask : t_mask
   task automatic t_thermal;
      for (int g = G_TALERT; g <= G_TBATT; g++) begin
         u_host.wr(ADDR_MASK_BASE + 8'(g), 8'h00);
      end
      @(posedge core_clk);
      thermal_alert_event <= 8'hFF;
      thermal_critical_event <= 4'hF;
      battery_thermal_event <= 6'h3F;
      @(posedge core_clk);
      thermal_alert_event <= 8'h00;
      thermal_critical_event <= 4'h0;
      battery_thermal_event <= 6'h00;
      for (int g = G_TALERT; g <= G_TBATT; g++) begin
         u_host.service(ADDR_POWER_SOURCE + 8'(g), f, v);
         check(f, 8'h02);
         check(v, WIDTH_MASK[g]);
      end
      tick(4);
      ci(1'b0);
   endtask : t_thermal
   task automatic t_levels;
      u_host.wr(ADDR_MASK_BASE + 8'(G_POWER), 8'h00);
      u_host.wr(ADDR_MASK_BASE + 8'(G_BURST), 8'h00);
      u_host.wr(ADDR_MASK_BASE + 8'(G_HDMI), 8'h00);
      for (int k = 0; k < 2; k++) begin
         @(posedge core_clk);
         power_source_level <= (k == 0) ? 3'h7 : 3'h0;
         supply_compare_level <= (k == 0) ? 3'h7 : 3'h0;
         hdmi_supply_overcurrent <= (k == 0);
         tick(5);
         rc(ADDR_FIRST_LEVEL, (k == 0) ? 8'h25 : 8'h05);
         u_host.service(ADDR_POWER_SOURCE, f, v);
         check(v, 8'h07);
         u_host.service(ADDR_BURST_CONTROL, f, v);
         check(v, 8'h07);
         u_host.service(ADDR_HDMI_SUPPLY, f, v);
         check(v, (k == 0) ? 8'h01 : 8'h00);
      end
   endtask : t_levels
   task automatic t_charger;
      u_host.wr(ADDR_MASK_BASE + 8'(G_CHARGER), 8'h00);
      for (int k = 0; k < 2; k++) begin
         @(posedge core_clk);
         charger_request_n <= 1'b0;
         repeat (CHG - 1 + k) @(posedge core_clk);
         charger_request_n <= 1'b1;
         tick(4);
         rc(ADDR_CHARGER, (k == 0) ? 8'h00 : 8'h01);
      end
      rc(ADDR_FIRST_LEVEL, 8'h10);
      u_host.wr(ADDR_CHARGER, 8'h01);
   endtask : t_charger
   task automatic t_pins;
      u_host.wr(ADDR_EDGE_RISE, 8'h03);
      u_host.wr(ADDR_EDGE_FALL, 8'h06);
      u_host.wr(ADDR_MASK_BASE + 8'(G_PIN), 8'h00);
      for (int k = 0; k < 2; k++) begin
         @(posedge core_clk);
         pin_level <= (k == 0) ? 8'hFF : 8'h00;
         tick(5);
         u_host.service(ADDR_PIN_EDGE, f, v);
         check(f, 8'h10);
         check(v, (k == 0) ? 8'h03 : 8'h06);
      end
   endtask : t_pins
   task automatic stop_test;
      if (bad_count == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : stop_test
   // hang guard, well above the few hundred cycles the run needs
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         bad_count++;
         stop_test();
      end
   end
   initial begin
      repeat (4) @(posedge core_clk);
      reset <= 1'b0;
      t_reset();
      t_conv();
      t_mask();
      t_thermal();
      t_levels();
      t_charger();
      t_pins();
      stop_test();
   end
endmodule : tb_tlic_controller
